// ===== hw/ftm_top.sv
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module ftm_top (
   input  wire logic                          mclk_i,
   input  wire logic                          rstn_i,
   input  wire logic                          mode_select_serial_in_i,
   input  wire logic                          wr_en_i,
   input  wire logic [ftm_pkg::DATA_W-1:0]    wr_data_i,
   input  wire logic                          rd_en_i,
   output logic      [ftm_pkg::DATA_W-1:0]    data_out_bus_o,
   output ftm_pkg::ftm_flags_t                flags_o,
   input  wire logic [ftm_pkg::ADDR_W-1:0]    reg_addr_i,
   input  wire logic [ftm_pkg::REG_W-1:0]     reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic      [ftm_pkg::REG_W-1:0]     reg_rdata_o,
   output logic                               irq_o
);

   // ********************************************************************
   // Mode capture
   // ********************************************************************
   // The synchroniser runs through reset so the pin level is settled
   // by the time it is captured; reset must last three cycles.
   logic                 msel_s1_q;
   logic                 msel_s2_q;
   ftm_pkg::ftm_mode_t   mode_q;
   logic                 first_word_fall_through;

   always_ff @(posedge mclk_i) begin
      msel_s1_q <= mode_select_serial_in_i;
      msel_s2_q <= msel_s1_q;
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         mode_q <= msel_s2_q ? ftm_pkg::FTM_MODE_FIRST_WORD_FALL_THROUGH
                             : ftm_pkg::FTM_MODE_STD;
      end
   end

   assign first_word_fall_through = (mode_q == ftm_pkg::FTM_MODE_FIRST_WORD_FALL_THROUGH);

   // ********************************************************************
   // Pointers and occupancy
   // ********************************************************************
   logic [ftm_pkg::PTR_W-1:0]  wptr_q;
   logic [ftm_pkg::PTR_W-1:0]  rptr_q;
   logic [ftm_pkg::CNT_W-1:0]  count_q;
   logic [ftm_pkg::CNT_W-1:0]  count_d;
   logic [ftm_pkg::DATA_W-1:0] ram_rdata;
   logic [ftm_pkg::DATA_W-1:0] dout_q;
   logic                       ov_q;
   logic                       mem_nonempty;
   logic                       full_core;
   logic                       avail_p;
   logic                       space_p;
   logic                       mem_vis;
   logic                       space_vis;
   logic                       wr_ok;
   logic                       std_rd;
   logic                       first_word_fall_through_load;
   logic                       pop;
   logic                       rd_ignored;

   assign mem_nonempty = (count_q != '0);
   // In fall-through mode the output register holds one extra word.
   assign full_core = (count_q == ftm_pkg::DEPTH_CNT) && (!first_word_fall_through || ov_q);

   ftm_pipe #(
      .STAGES  (ftm_pkg::AVAIL_STAGES),
      .RST_VAL (1'b0)
   ) u_avail_pipe (
      .mclk_i (mclk_i),
      // An empty store flushes the pipe so a refill waits the full latency.
      .rstn_i (rstn_i && mem_nonempty),
      .d_i    (mem_nonempty),
      .q_o    (avail_p)
   );

   ftm_pipe #(
      .STAGES  (ftm_pkg::SPACE_STAGES),
      .RST_VAL (1'b1)
   ) u_space_pipe (
      .mclk_i (mclk_i),
      .rstn_i (rstn_i),
      .d_i    (!full_core),
      .q_o    (space_p)
   );

   // Freshly written words show late; losing data shows at once.
   assign mem_vis   = avail_p && mem_nonempty;
   assign space_vis = space_p && !full_core;

   assign wr_ok     = wr_en_i && space_vis;
   assign std_rd    = !first_word_fall_through && rd_en_i && mem_vis;
   assign first_word_fall_through_load = first_word_fall_through && mem_vis && (!ov_q || rd_en_i);
   assign pop       = std_rd || first_word_fall_through_load;
   assign rd_ignored = rd_en_i && (first_word_fall_through ? !ov_q : !mem_vis);

   always_comb begin
      count_d = count_q;
      if (wr_ok && !pop) begin
         count_d = count_q + 5'h01;
      end else if (pop && !wr_ok) begin
         count_d = count_q - 5'h01;
      end
   end

   ftm_ram u_ram (
      .mclk_i  (mclk_i),
      .we_i    (wr_ok),
      .waddr_i (wptr_q),
      .wdata_i (wr_data_i),
      .raddr_i (rptr_q),
      .rdata_o (ram_rdata)
   );

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         wptr_q  <= '0;
         rptr_q  <= '0;
         count_q <= '0;
      end else begin
         count_q <= count_d;
         if (wr_ok) begin
            wptr_q <= wptr_q + 4'h1;
         end
         if (pop) begin
            rptr_q <= rptr_q + 4'h1;
         end
      end
   end

   // ********************************************************************
   // Output register
   // ********************************************************************
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         dout_q <= ftm_pkg::DOUT_RST;
         ov_q   <= 1'b0;
      end else begin
         if (pop) begin
            dout_q <= ram_rdata;
         end
         if (first_word_fall_through_load) begin
            ov_q <= 1'b1;
         end else if (first_word_fall_through && rd_en_i) begin
            ov_q <= 1'b0;
         end
      end
   end

   assign data_out_bus_o = dout_q;

   // Flags of the mode not selected are held low.
   assign flags_o.output_valid     = first_word_fall_through && ov_q;
   assign flags_o.input_space_flag = first_word_fall_through && space_vis;
   assign flags_o.no_words_flag    = !first_word_fall_through && !mem_vis;
   assign flags_o.no_space_flag    = !first_word_fall_through && !space_vis;

   // ********************************************************************
   // Events and registers
   // ********************************************************************
   logic [ftm_pkg::EV_W-1:0] status_q;
   logic [ftm_pkg::EV_W-1:0] mask_q;
   logic [ftm_pkg::EV_W-1:0] ev;
   logic [ftm_pkg::EV_W-1:0] clr;
   logic                     full_prev_q;
   logic                     vis_prev_q;
   logic                     vis_now;
   logic [ftm_pkg::REG_W-1:0] state_word;

   assign vis_now = first_word_fall_through ? ov_q : mem_vis;

   always_comb begin
      ev = '0;
      ev[ftm_pkg::EV_WR_BLOCK] = wr_en_i && !space_vis;
      ev[ftm_pkg::EV_RD_IGN]   = rd_ignored;
      ev[ftm_pkg::EV_FULL]     = full_core && !full_prev_q;
      ev[ftm_pkg::EV_AVAIL]    = vis_now && !vis_prev_q;
   end

   assign clr = (reg_wr_i && reg_addr_i == ftm_pkg::ADDR_STATUS)
                ? reg_wdata_i[ftm_pkg::EV_W-1:0] : '0;

   // A new event beats a simultaneous write-one-to-clear.
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         status_q    <= ftm_pkg::STATUS_RST;
         full_prev_q <= 1'b0;
         vis_prev_q  <= 1'b0;
      end else begin
         status_q    <= (status_q & ~clr) | ev;
         full_prev_q <= full_core;
         vis_prev_q  <= vis_now;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         mask_q <= ftm_pkg::MASK_RST;
      end else if (reg_wr_i && reg_addr_i == ftm_pkg::ADDR_MASK) begin
         mask_q <= reg_wdata_i[ftm_pkg::EV_W-1:0];
      end
   end

   always_comb begin
      state_word = '0;
      state_word[ftm_pkg::STATE_MODE_POS] = first_word_fall_through;
      state_word[ftm_pkg::STATE_FLAGS_POS +: 4] = flags_o;
      state_word[ftm_pkg::STATE_CNT_POS +: ftm_pkg::CNT_W] = count_q;
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            ftm_pkg::ADDR_STATUS: begin
               reg_rdata_o <= {28'h0000000, status_q};
            end
            ftm_pkg::ADDR_MASK: begin
               reg_rdata_o <= {28'h0000000, mask_q};
            end
            ftm_pkg::ADDR_STATE: begin
               reg_rdata_o <= state_word;
            end
            default: begin
               reg_rdata_o <= '0;
            end
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   assign irq_o = |(status_q & mask_q);

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_first_word_fall_through_first_wr;
      first_word_fall_through && count_q == '0 && !ov_q && wr_ok;
   endsequence

   sequence s_std_first_wr;
      !first_word_fall_through && count_q == '0 && wr_ok;
   endsequence

   property p_mode_capture;
      rstn_i && !$past(rstn_i) |->
         mode_q == ($past(msel_s2_q) ? ftm_pkg::FTM_MODE_FIRST_WORD_FALL_THROUGH
                                     : ftm_pkg::FTM_MODE_STD);
   endproperty
   a_mode_capture: assert property (p_mode_capture)
      else $error("Mode not taken from pin during reset.");

   property p_mode_hold;
      rstn_i && $past(rstn_i) |-> $stable(mode_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("Mode changed outside master reset.");

   property p_first_word_fall_through_latency;
      s_first_word_fall_through_first_wr |=> !ov_q [*3] ##1 ov_q;
   endproperty
   a_first_word_fall_through_latency: assert property (p_first_word_fall_through_latency)
      else $error("First word not shown after three edges.");

   property p_std_latency;
      s_std_first_wr |=> flags_o.no_words_flag [*2]
         ##1 !flags_o.no_words_flag;
   endproperty
   a_std_latency: assert property (p_std_latency)
      else $error("No-words flag did not clear after two edges.");

   property p_full_block;
      wr_en_i && !space_vis |=> wptr_q == $past(wptr_q);
   endproperty
   a_full_block: assert property (p_full_block)
      else $error("Write accepted without free space.");

   property p_rd_empty;
      rd_en_i && !first_word_fall_through && !mem_vis |=>
         rptr_q == $past(rptr_q) && $stable(dout_q);
   endproperty
   a_rd_empty: assert property (p_rd_empty)
      else $error("Read acted on an empty FIFO.");

   property p_space_latency;
      $fell(full_core) |-> !space_vis ##1 !space_vis ##1 space_vis;
   endproperty
   a_space_latency: assert property (p_space_latency)
      else $error("Space flag did not return after two stages.");

   property p_first_word_fall_through_hold;
      first_word_fall_through && ov_q && !rd_en_i |=> ov_q && $stable(dout_q);
   endproperty
   a_first_word_fall_through_hold: assert property (p_first_word_fall_through_hold)
      else $error("Presented word lost without a read.");

   property p_std_flags;
      !first_word_fall_through && count_q == ftm_pkg::DEPTH_CNT |->
         flags_o.no_space_flag && !flags_o.input_space_flag;
   endproperty
   a_std_flags: assert property (p_std_flags)
      else $error("Standard full not shown on no-space flag.");

endmodule

// ===== hw/ftm_pkg.sv
// Behaviour
// - Mode pin sampled during reset fixes mode.
// - Pin high at reset selects fall-through mode.
// - Fall-through: output-valid and input-space flags used.
// - First word appears after three edges, unrequested.
// - Pin low at reset selects standard mode.
// - Standard: no-words and no-space flags used.
// - Standard: no-words clears two edges after write.
// - Full shows no space and blocks writes.
// - Read request ignored while FIFO empty.
// - Valid flag three stages, space flag two.
package ftm_pkg;

   // ********************************************************************
   // Sizes
   // ********************************************************************
   localparam int DATA_W = 18;
   localparam int DEPTH  = 16;
   localparam int PTR_W  = 4;
   localparam int CNT_W  = 5;
   localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;

   // ********************************************************************
   // Flag pipeline depths
   // ********************************************************************
   // The fall-through valid register itself is the third stage.
   localparam int AVAIL_STAGES = 2;
   localparam int SPACE_STAGES = 2;

   // ********************************************************************
   // Register map
   // ********************************************************************
   localparam int ADDR_W  = 4;
   localparam int REG_W   = 32;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_STATE  = 4'h8;

   localparam int EV_W        = 4;
   localparam int EV_WR_BLOCK = 0;
   localparam int EV_RD_IGN   = 1;
   localparam int EV_FULL     = 2;
   localparam int EV_AVAIL    = 3;
   localparam logic [EV_W-1:0] STATUS_RST = 4'h0;
   localparam logic [EV_W-1:0] MASK_RST   = 4'h0;

   localparam int STATE_MODE_POS  = 0;
   localparam int STATE_FLAGS_POS = 1;
   localparam int STATE_CNT_POS   = 5;
   localparam logic [DATA_W-1:0] DOUT_RST = 18'h00000;

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [1:0] {
      FTM_MODE_STD  = 2'b01,
      FTM_MODE_FIRST_WORD_FALL_THROUGH = 2'b10
   } ftm_mode_t;

   typedef struct packed {
      logic output_valid;
      logic input_space_flag;
      logic no_words_flag;
      logic no_space_flag;
   } ftm_flags_t;

endpackage

// ===== hw/ftm_pipe.sv
`timescale 1ns/1ps
module ftm_pipe #(
   parameter int   STAGES  = 2,
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic mclk_i,
   input  wire logic rstn_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic [STAGES-1:0] sh_q;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sh_q <= {STAGES{RST_VAL}};
      end else begin
         sh_q <= {sh_q[STAGES-2:0], d_i};
      end
   end

   assign q_o = sh_q[STAGES-1];

endmodule

// ===== hw/ftm_ram.sv
`timescale 1ns/1ps
module ftm_ram (
   input  wire logic                         mclk_i,
   input  wire logic                         we_i,
   input  wire logic [ftm_pkg::PTR_W-1:0]    waddr_i,
   input  wire logic [ftm_pkg::DATA_W-1:0]   wdata_i,
   input  wire logic [ftm_pkg::PTR_W-1:0]    raddr_i,
   output logic      [ftm_pkg::DATA_W-1:0]   rdata_o
);

   logic [ftm_pkg::DATA_W-1:0] mem_q [ftm_pkg::DEPTH];

   always_ff @(posedge mclk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem_q[raddr_i];

endmodule

// ===== dv/ftm_peer.sv
`timescale 1ns/1ps
module ftm_peer #(
   parameter logic [ftm_pkg::DATA_W-1:0] BASE = 18'h00100
) (
   input  wire logic                        mclk_i,
   input  wire logic                        rstn_i,
   input  wire logic                        wr_go_i,
   input  wire logic                        rd_go_i,
   output logic                             wr_en_o,
   output logic      [ftm_pkg::DATA_W-1:0]  wr_data_o,
   output logic                             rd_en_o
);
   logic [ftm_pkg::DATA_W-1:0] word_q;

   // ******************************************************************
   // Writer
   // ******************************************************************
   // Every attempted write uses up a word, so a refused one leaves a gap.
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         word_q <= BASE;
      end else if (wr_go_i) begin
         word_q <= word_q + 18'h00001;
      end
   end
   // Idle data is inverted so that a stale word can never pass as fresh.
   assign wr_data_o = wr_go_i ? word_q : ~word_q;
   assign wr_en_o   = wr_go_i;

   // ******************************************************************
   // Reader
   // ******************************************************************
   assign rd_en_o = rd_go_i;
endmodule

// ===== dv/test_fifo_timing_mode_select.sv
`timescale 1ns/1ps
module test_fifo_timing_mode_select;
   typedef struct {
      logic [3:0]  addr;
      logic        wr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } ftm_row_t;

   localparam logic [17:0] BASE = 18'h00100;
   logic        mclk_i, rstn_i, mode_i, wr_go, rd_go, wr_en, rd_en, irq_o;
   logic        reg_wr_i, reg_rd_i;
   logic [3:0]  reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, v;
   logic [17:0] wr_data, dout;
   ftm_pkg::ftm_flags_t flags;
   int          fail_count, tests_run;
   ftm_row_t    rows [6];

   ftm_peer #(.BASE(BASE)) u_peer (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .wr_go_i(wr_go), .rd_go_i(rd_go), .wr_en_o(wr_en),
      .wr_data_o(wr_data), .rd_en_o(rd_en));
   ftm_top u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .mode_select_serial_in_i(mode_i), .wr_en_i(wr_en),
      .wr_data_i(wr_data), .rd_en_i(rd_en), .data_out_bus_o(dout),
      .flags_o(flags), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .irq_o(irq_o));

   initial mclk_i = 1'b0;
   always #5 mclk_i = ~mclk_i;

   // ******************************************************************
   // Tasks
   // ******************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset(input logic mode);
      rstn_i <= 1'b0;
      mode_i <= mode;
      wr_go  <= 1'b0;
      rd_go  <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      // The pin moves after reset; the captured mode must not follow it.
      mode_i <= ~mode;
      #1;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i   <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ******************************************************************
   // Watchdog
   // ******************************************************************
   // The whole sequence needs about 80 cycles; 5000 leaves wide margin.
   initial begin
      repeat (5000) @(posedge mclk_i);
      fail_count++;
      print_verdict();
   end

   // ******************************************************************
   // Sequence
   // ******************************************************************
   initial begin
      fail_count = 0;
      tests_run = 0;
      {rstn_i, mode_i, wr_go, rd_go, reg_wr_i, reg_rd_i} = 6'h00;
      reg_addr_i = 4'h0;
      reg_wdata_i = 32'h00000000;
      rows[0] = '{ftm_pkg::ADDR_STATUS, 1'b0, 32'h00000000, 32'h00000000};
      rows[1] = '{ftm_pkg::ADDR_MASK, 1'b0, 32'h00000000, 32'h00000000};
      rows[2] = '{ftm_pkg::ADDR_MASK, 1'b1, 32'h0000000F, 32'h0000000F};
      rows[3] = '{4'hC, 1'b1, 32'h0000FFFF, 32'h00000000};
      rows[4] = '{ftm_pkg::ADDR_STATE, 1'b1, 32'hFFFFFFFF, 32'h00000004};
      rows[5] = '{ftm_pkg::ADDR_MASK, 1'b1, 32'h00000000, 32'h00000000};
      do_reset(1'b0);
      check({28'h0000000, flags}, 32'h00000002);
      foreach (rows[i]) begin
         if (rows[i].wr) reg_wr(rows[i].addr, rows[i].wdata);
         reg_rd(rows[i].addr, v);
         check(v, rows[i].exp);
      end
      $display("register table test done");

      rd_go <= 1'b1;
      @(posedge mclk_i);
      rd_go <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1 check(dout, 32'h0);
      check(irq_o, 1'b0);
      reg_rd(ftm_pkg::ADDR_STATUS, v);
      check(v, 32'h00000002);
      reg_wr(ftm_pkg::ADDR_MASK, 32'h00000002);
      #1 check(irq_o, 1'b1);
      reg_wr(ftm_pkg::ADDR_STATUS, 32'h00000002);
      #1 check(irq_o, 1'b0);
      $display("empty read and interrupt test done");

      wr_go <= 1'b1;
      @(posedge mclk_i);
      wr_go <= 1'b0;
      for (int i = 1; i <= 3; i++) begin
         #1 check(flags.no_words_flag, i < 3);
         check(dout, 32'h0);
         if (i < 3) @(posedge mclk_i);
      end
      rd_go <= 1'b1;
      @(posedge mclk_i);
      rd_go <= 1'b0;
      #1 check(dout, BASE);
      check(flags.no_words_flag, 1'b1);
      $display("standard single word test done");

      wr_go <= 1'b1;
      repeat (17) @(posedge mclk_i);
      wr_go <= 1'b0;
      #1 check(flags.no_space_flag, 1'b1);
      reg_rd(ftm_pkg::ADDR_STATUS, v);
      check(v, 32'h0000000D);
      reg_rd(ftm_pkg::ADDR_STATE, v);
      check(v, 32'h00000202);
      rd_go <= 1'b1;
      for (int i = 1; i <= 16; i++) begin
         @(posedge mclk_i);
         if (i == 16) rd_go <= 1'b0;
         #1 check(dout, BASE + 18'(i));
      end
      rd_go <= 1'b1;
      @(posedge mclk_i);
      rd_go <= 1'b0;
      #1 check(dout, BASE + 18'h00010);
      check(flags.no_words_flag, 1'b1);
      $display("standard fill and drain test done");

      do_reset(1'b1);
      check({28'h0000000, flags}, 32'h00000004);
      wr_go <= 1'b1;
      @(posedge mclk_i);
      wr_go <= 1'b0;
      for (int i = 1; i <= 3; i++) begin
         #1 check(flags.output_valid, 1'b0);
         @(posedge mclk_i);
      end
      #1 check(flags.output_valid, 1'b1);
      check(dout, BASE);
      repeat (3) @(posedge mclk_i);
      #1 check(dout, BASE);
      wr_go <= 1'b1;
      repeat (2) @(posedge mclk_i);
      wr_go <= 1'b0;
      repeat (5) @(posedge mclk_i);
      rd_go <= 1'b1;
      for (int i = 1; i <= 3; i++) begin
         @(posedge mclk_i);
         if (i == 3) rd_go <= 1'b0;
         #1 check(flags.output_valid, i < 3);
         if (i < 3) check(dout, BASE + 18'(i));
      end
      reg_rd(ftm_pkg::ADDR_STATE, v);
      check(v, 32'h00000009);
      $display("fall-through test done");
      print_verdict();
   end
endmodule
